// ### core/rfcfg_pkg.sv
package rfcfg_pkg;

  // ===========================================================================
  // Register offsets
  localparam logic [5:0] RFCFG_ADDR_RSVD_A = 6'h23;
  localparam logic [5:0] RFCFG_ADDR_MOD_WIDTH = 6'h24;
  localparam logic [5:0] RFCFG_ADDR_RSVD_B = 6'h25;
  localparam logic [5:0] RFCFG_ADDR_RX_GAIN = 6'h26;
  localparam logic [5:0] RFCFG_ADDR_NDRV = 6'h27;
  localparam logic [5:0] RFCFG_ADDR_PDRV_CW = 6'h28;

  // ===========================================================================
  // Reset values
  localparam logic [7:0] RFCFG_RST_RSVD_A = 8'h88;
  localparam logic [7:0] RFCFG_RST_MOD_WIDTH = 8'h26;
  localparam logic [7:0] RFCFG_RST_RSVD_B = 8'h87;
  localparam logic [7:0] RFCFG_RST_RX_GAIN = 8'h48;
  localparam logic [7:0] RFCFG_RST_NDRV = 8'h88;
  localparam logic [7:0] RFCFG_RST_PDRV_CW = 8'h20;
  localparam logic [7:0] RFCFG_UNMAPPED_DATA = 8'h00;

  // ===========================================================================
  // Field positions
  localparam int RFCFG_GAIN_LSB = 4;
  localparam int RFCFG_GAIN_MSB = 6;
  localparam int RFCFG_NDRV_CW_LSB = 4;
  localparam int RFCFG_NDRV_CW_MSB = 7;
  localparam int RFCFG_NDRV_MOD_LSB = 0;
  localparam int RFCFG_NDRV_MOD_MSB = 3;
  localparam int RFCFG_PDRV_LSB = 0;
  localparam int RFCFG_PDRV_MSB = 5;

  // ===========================================================================
  // Receiver gain in dB
  localparam logic [5:0] RFCFG_GAIN_18DB = 6'h12;
  localparam logic [5:0] RFCFG_GAIN_23DB = 6'h17;
  localparam logic [5:0] RFCFG_GAIN_33DB = 6'h21;
  localparam logic [5:0] RFCFG_GAIN_38DB = 6'h26;
  localparam logic [5:0] RFCFG_GAIN_43DB = 6'h2B;
  localparam logic [5:0] RFCFG_GAIN_48DB = 6'h30;

  // ===========================================================================
  // Host register access, one request per cycle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } rfcfg_req_type;

  // Settings handed to the analogue drivers
  typedef struct packed {
    logic [3:0] ndrv;
    logic [5:0] pdrv;
  } rfcfg_drive_type;

endpackage

// ### core/rfcfg_regs.sv
`timescale 1ns/1ps
// How it works
// - Modulation width register at 24h, reset 26h; pulse lasts value plus one carrier periods.
// - Receiver config at 26h, reset 48h; gain in bits 6:4, rest reserved.
// - Gain codes 000/010 18 dB, 001/011 23 dB, 100..111 33/38/43/48 dB.
// - Location 23h is reserved, reset 88h, no function.
// - Location 25h is reserved, reset 87h, no function.
// - N-driver register at 27h, reset 88h; carrier in 7:4, modulation in 3:0.
// - N-driver settings reach the drivers only while an antenna output is on.
// - Soft power-down forces the p-driver top bit high, and the n-driver top bit only while an antenna output is on.
// - Conductance fields are binary weighted, each bit double the one below.
// - P-driver carrier register at 28h, reset 20h; 6-bit field in 5:0.
// - During modulation the n-driver uses its modulation field, not the carrier field.
module rfcfg_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire rfcfg_pkg::rfcfg_req_type req_i,
  input wire logic soft_pd_i,
  input wire logic antenna_out_one_on_i,
  input wire logic antenna_out_two_on_i,
  input wire logic carrier_tick_i,
  input wire logic mod_start_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic [5:0] gain_db_o,
  output logic [2:0] receiver_gain_code_o,
  output logic mod_pulse_o,
  output rfcfg_pkg::rfcfg_drive_type drive_o
);
  import rfcfg_pkg::*;

  // ===========================================================================
  // Stored fields
  logic [7:0] pulse_width_value_reg;
  logic [2:0] receiver_gain_code_reg;
  logic [3:0] ndriver_carrier_strength_reg;
  logic [3:0] ndriver_modulation_strength_reg;
  logic [5:0] pdriver_carrier_strength_reg;
  logic [7:0] rdata_next;
  logic [5:0] gain_db_next;
  logic [3:0] ndrv_next;
  logic [5:0] pdrv_next;
  logic [7:0] pulse_cnt_reg;
  logic drivers_on;

  // ===========================================================================
  // Host writes; reserved bits and locations hold no storage at all
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_width_value_reg <= RFCFG_RST_MOD_WIDTH;
      receiver_gain_code_reg <= RFCFG_RST_RX_GAIN[RFCFG_GAIN_MSB:RFCFG_GAIN_LSB];
      ndriver_carrier_strength_reg <= RFCFG_RST_NDRV[RFCFG_NDRV_CW_MSB:RFCFG_NDRV_CW_LSB];
      ndriver_modulation_strength_reg <= RFCFG_RST_NDRV[RFCFG_NDRV_MOD_MSB:RFCFG_NDRV_MOD_LSB];
      pdriver_carrier_strength_reg <= RFCFG_RST_PDRV_CW[RFCFG_PDRV_MSB:RFCFG_PDRV_LSB];
    end else if (req_i.wr) begin
      unique case (req_i.addr)
        RFCFG_ADDR_MOD_WIDTH: pulse_width_value_reg <= req_i.wdata;
        RFCFG_ADDR_RX_GAIN: begin
          receiver_gain_code_reg <= req_i.wdata[RFCFG_GAIN_MSB:RFCFG_GAIN_LSB];
        end
        RFCFG_ADDR_NDRV: begin
          ndriver_carrier_strength_reg <= req_i.wdata[RFCFG_NDRV_CW_MSB:RFCFG_NDRV_CW_LSB];
          ndriver_modulation_strength_reg <= req_i.wdata[RFCFG_NDRV_MOD_MSB:RFCFG_NDRV_MOD_LSB];
        end
        RFCFG_ADDR_PDRV_CW: begin
          pdriver_carrier_strength_reg <= req_i.wdata[RFCFG_PDRV_MSB:RFCFG_PDRV_LSB];
        end
        default: begin
          // Reserved and unmapped locations swallow the write
        end
      endcase
    end
  end

  // ===========================================================================
  // Read mux
  always_comb begin
    rdata_next = RFCFG_UNMAPPED_DATA;
    unique case (req_i.addr)
      RFCFG_ADDR_RSVD_A: rdata_next = RFCFG_RST_RSVD_A;
      RFCFG_ADDR_MOD_WIDTH: rdata_next = pulse_width_value_reg;
      RFCFG_ADDR_RSVD_B: rdata_next = RFCFG_RST_RSVD_B;
      RFCFG_ADDR_RX_GAIN: begin
        rdata_next = RFCFG_RST_RX_GAIN;
        rdata_next[RFCFG_GAIN_MSB:RFCFG_GAIN_LSB] = receiver_gain_code_reg;
      end
      RFCFG_ADDR_NDRV: rdata_next = {ndriver_carrier_strength_reg, ndriver_modulation_strength_reg};
      RFCFG_ADDR_PDRV_CW: begin
        rdata_next = RFCFG_RST_PDRV_CW;
        rdata_next[RFCFG_PDRV_MSB:RFCFG_PDRV_LSB] = pdriver_carrier_strength_reg;
      end
      default: rdata_next = RFCFG_UNMAPPED_DATA;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= RFCFG_UNMAPPED_DATA;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= req_i.rd;
      if (req_i.rd) begin
        rdata_o <= rdata_next;
      end
    end
  end

  // ===========================================================================
  // Receiver gain decode
  always_comb begin
    gain_db_next = RFCFG_GAIN_18DB;
    unique case (receiver_gain_code_reg)
      3'h0, 3'h2: gain_db_next = RFCFG_GAIN_18DB;
      3'h1, 3'h3: gain_db_next = RFCFG_GAIN_23DB;
      3'h4: gain_db_next = RFCFG_GAIN_33DB;
      3'h5: gain_db_next = RFCFG_GAIN_38DB;
      3'h6: gain_db_next = RFCFG_GAIN_43DB;
      3'h7: gain_db_next = RFCFG_GAIN_48DB;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_db_o <= RFCFG_GAIN_33DB;
      receiver_gain_code_o <= RFCFG_RST_RX_GAIN[RFCFG_GAIN_MSB:RFCFG_GAIN_LSB];
    end else begin
      gain_db_o <= gain_db_next;
      receiver_gain_code_o <= receiver_gain_code_reg;
    end
  end

  // ===========================================================================
  // Modulation pulse, counted in carrier ticks
  // A start during a running pulse is ignored so the width is never cut short
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mod_pulse_o <= 1'b0;
      pulse_cnt_reg <= 8'h00;
    end else if (!mod_pulse_o) begin
      if (mod_start_i) begin
        mod_pulse_o <= 1'b1;
        pulse_cnt_reg <= pulse_width_value_reg;
      end
    end else if (carrier_tick_i) begin
      if (pulse_cnt_reg == 8'h00) begin
        mod_pulse_o <= 1'b0;
      end else begin
        pulse_cnt_reg <= pulse_cnt_reg - 8'h01;
      end
    end
  end

  // ===========================================================================
  // Driver strengths
  // Codes pass through unscaled: the driver legs are binary weighted,
  // so the code itself is the conductance in units of the lowest leg
  assign drivers_on = antenna_out_one_on_i | antenna_out_two_on_i;

  always_comb begin
    ndrv_next = mod_pulse_o ? ndriver_modulation_strength_reg
                            : ndriver_carrier_strength_reg;
    pdrv_next = pdriver_carrier_strength_reg;
    if (soft_pd_i) begin
      ndrv_next[3] = 1'b1;
      pdrv_next[5] = 1'b1;
    end
    if (!drivers_on) begin
      ndrv_next = 4'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_o <= '0;
    end else begin
      drive_o.ndrv <= ndrv_next;
      drive_o.pdrv <= pdrv_next;
    end
  end

  // ===========================================================================
  // Pulse checks
  // Ticks are counted in helper flops; a repetition of up to 256 would choke the tools
  logic [8:0] ticks_seen_reg;
  logic [8:0] width_seen_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ticks_seen_reg <= 9'h000;
      width_seen_reg <= 9'h000;
    end else if (!mod_pulse_o && mod_start_i) begin
      ticks_seen_reg <= 9'h000;
      width_seen_reg <= {1'b0, pulse_width_value_reg} + 9'h001;
    end else if (mod_pulse_o && carrier_tick_i) begin
      ticks_seen_reg <= ticks_seen_reg + 9'h001;
    end
  end

  a_pulse_length: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(mod_pulse_o) |-> ticks_seen_reg == width_seen_reg)
    else $error("modulation pulse length differs from width plus one");

  a_pulse_start: assert property (@(posedge clk_i) disable iff (rst_i)
    !mod_pulse_o && mod_start_i |=> mod_pulse_o)
    else $error("modulation pulse did not start");

  a_pulse_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !mod_pulse_o && !mod_start_i |=> !mod_pulse_o)
    else $error("modulation pulse started without a request");

  // ===========================================================================
  // Register port checks

  a_width_write: assert property (@(posedge clk_i) disable iff (rst_i)
    req_i.wr && req_i.addr == RFCFG_ADDR_MOD_WIDTH ##1 req_i.rd && req_i.addr ==
      RFCFG_ADDR_MOD_WIDTH |=> rdata_o == $past(req_i.wdata, 2))
    else $error("modulation width does not read back");

  a_gain_readback: assert property (@(posedge clk_i) disable iff (rst_i)
    req_i.rd && req_i.addr == RFCFG_ADDR_RX_GAIN |=> rdata_o[7] == 1'b0 &&
      rdata_o[3:0] == 4'h8 && rdata_o[6:4] == $past(receiver_gain_code_reg))
    else $error("receiver config reserved bits wrong");

  a_gain_decode: assert property (@(posedge clk_i) disable iff (rst_i)
    $stable(receiver_gain_code_reg) ##1 receiver_gain_code_reg[2:1] == 2'b00 |=>
      gain_db_o == RFCFG_GAIN_18DB + 6'h05 * $past(receiver_gain_code_reg[0]) &&
      gain_db_o >= RFCFG_GAIN_18DB)
    else $error("low gain codes decode wrong");

  a_rsvd_a_read: assert property (@(posedge clk_i) disable iff (rst_i)
    req_i.rd && req_i.addr == RFCFG_ADDR_RSVD_A |=> rvalid_o && rdata_o == 8'h88)
    else $error("reserved 23h reads wrong");

  a_rsvd_b_read: assert property (@(posedge clk_i) disable iff (rst_i)
    req_i.rd && req_i.addr == RFCFG_ADDR_RSVD_B |=> rvalid_o && rdata_o == 8'h87)
    else $error("reserved 25h reads wrong");

  a_gain_high: assert property (@(posedge clk_i) disable iff (rst_i)
    receiver_gain_code_reg[2] |=>
      gain_db_o == RFCFG_GAIN_33DB + 6'h05 * $past(receiver_gain_code_reg[1:0]))
    else $error("high gain codes decode wrong");

  a_gain_code_out: assert property (@(posedge clk_i) disable iff (rst_i)
    req_i.wr && req_i.addr == RFCFG_ADDR_RX_GAIN |=> ##1
      receiver_gain_code_o == $past(req_i.wdata[RFCFG_GAIN_MSB:RFCFG_GAIN_LSB], 2))
    else $error("gain code output does not follow the write");

  a_ndrv_write: assert property (@(posedge clk_i) disable iff (rst_i)
    req_i.wr && req_i.addr == RFCFG_ADDR_NDRV ##1 req_i.rd && req_i.addr ==
      RFCFG_ADDR_NDRV |=> rdata_o == $past(req_i.wdata, 2))
    else $error("n-driver conductance does not read back");

  // Only the low six bits are storage; the top two read as their reset value
  a_pdrv_write: assert property (@(posedge clk_i) disable iff (rst_i)
    req_i.wr && req_i.addr == RFCFG_ADDR_PDRV_CW ##1 req_i.rd && req_i.addr ==
      RFCFG_ADDR_PDRV_CW |=> rdata_o[RFCFG_PDRV_MSB:RFCFG_PDRV_LSB] ==
      $past(req_i.wdata[RFCFG_PDRV_MSB:RFCFG_PDRV_LSB], 2))
    else $error("p-driver conductance does not read back");

  // The answer is a one-cycle pulse; back-to-back reads keep it high
  a_read_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    req_i.rd |=> rvalid_o)
    else $error("read got no answer");

  a_no_stray_valid: assert property (@(posedge clk_i) disable iff (rst_i)
    !req_i.rd |=> !rvalid_o)
    else $error("read answer without a request");

  // ===========================================================================
  // Drive checks

  a_drivers_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !(antenna_out_one_on_i || antenna_out_two_on_i) |=> drive_o.ndrv == 4'h0)
    else $error("n-driver active with both outputs off");

  a_pd_force: assert property (@(posedge clk_i) disable iff (rst_i)
    soft_pd_i |=> drive_o.pdrv[5] &&
      (drive_o.ndrv[3] || !$past(antenna_out_one_on_i || antenna_out_two_on_i)))
    else $error("power-down did not force conductance top bit");

  a_mod_select: assert property (@(posedge clk_i) disable iff (rst_i)
    mod_pulse_o && (antenna_out_one_on_i || antenna_out_two_on_i) && !soft_pd_i |=>
      drive_o.ndrv == $past(ndriver_modulation_strength_reg))
    else $error("modulation conductance not applied");

  a_pdrv_rsvd: assert property (@(posedge clk_i) disable iff (rst_i)
    req_i.rd && req_i.addr == RFCFG_ADDR_PDRV_CW |=> rdata_o[7:6] == 2'b00)
    else $error("p-driver reserved bits not zero");

  a_pdrv_direct: assert property (@(posedge clk_i) disable iff (rst_i)
    !soft_pd_i |=> drive_o.pdrv == $past(pdriver_carrier_strength_reg))
    else $error("p-driver code not applied unscaled");

  a_carrier_select: assert property (@(posedge clk_i) disable iff (rst_i)
    !mod_pulse_o && (antenna_out_one_on_i || antenna_out_two_on_i) && !soft_pd_i |=>
      drive_o.ndrv == $past(ndriver_carrier_strength_reg))
    else $error("carrier conductance not applied");

endmodule // rfcfg_regs

// ### sim/rfcfg_host_model.sv
`timescale 1ns/1ps
// =============================================================================
// Host side of the register port
module rfcfg_host_model (
  input wire logic clk_i,
  output rfcfg_pkg::rfcfg_req_type req_o,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i
);
  import rfcfg_pkg::*;

  initial req_o = '0;

  // Idle address and data show the inverse, so a stale value never looks valid
  task wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task rd_reg(input logic [5:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'hA5};
    @(posedge clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'h5A};
    #1;
    d = rdata_i;
    v = rvalid_i;
  endtask

  // Write, then read the same location on the very next edge
  task wr_rd(input logic [5:0] a, input logic [7:0] wd, output logic [7:0] d);
    @(posedge clk_i);
    req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: wd};
    @(posedge clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~wd};
    @(posedge clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: wd};
    #1;
    d = rdata_i;
  endtask
endmodule // rfcfg_host_model

// ### sim/test_rf_frontend_config_regs.sv
`timescale 1ns/1ps
module test_rf_frontend_config_regs;
  import rfcfg_pkg::*;
  // ===========================================================================
  // Stimulus and design
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic soft_pd = 1'b0;
  logic one_on = 1'b0;
  logic two_on = 1'b0;
  logic tick = 1'b1;
  logic mod_start = 1'b0;
  rfcfg_req_type req;
  logic [7:0] rdata;
  logic rvalid;
  logic [5:0] gain_db;
  logic [2:0] gain_code;
  logic mod_pulse;
  rfcfg_drive_type drive;
  int error_cnt = 0;
  int n_tests = 0;
  logic [5:0] addrs [6] = '{6'h23, 6'h24, 6'h25, 6'h26, 6'h27, 6'h28};
  logic [7:0] rst_exp [6] = '{8'h88, 8'h26, 8'h87, 8'h48, 8'h88, 8'h20};
  logic [7:0] ff_exp [6] = '{8'h88, 8'hFF, 8'h87, 8'h78, 8'hFF, 8'h3F};
  logic [7:0] db_exp [8] = '{8'h12, 8'h17, 8'h12, 8'h17, 8'h21, 8'h26, 8'h2B, 8'h30};

  always #5 clk_i = ~clk_i;

  rfcfg_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .soft_pd_i(soft_pd),
    .antenna_out_one_on_i(one_on), .antenna_out_two_on_i(two_on), .carrier_tick_i(tick),
    .mod_start_i(mod_start), .rdata_o(rdata), .rvalid_o(rvalid), .gain_db_o(gain_db),
    .receiver_gain_code_o(gain_code), .mod_pulse_o(mod_pulse), .drive_o(drive));

  rfcfg_host_model host_u (.clk_i(clk_i), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid));

  // ===========================================================================
  // Shared helpers
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task rd_chk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    host_u.rd_reg(a, d, v);
    check({7'h00, v}, 8'h01);
    check(d, exp);
  endtask

  // Drive outputs lag their causes by one cycle
  task settle;
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  // ===========================================================================
  // Scenarios
  task t_reset;
    for (int i = 0; i < 6; i++) rd_chk(addrs[i], rst_exp[i]);
    check({2'h0, gain_db}, 8'h21);
    check({5'h00, gain_code}, 8'h04);
  endtask

  task t_rw;
    logic [7:0] d;
    for (int i = 0; i < 6; i++) host_u.wr_reg(addrs[i], 8'hFF);
    for (int i = 0; i < 6; i++) rd_chk(addrs[i], ff_exp[i]);
    host_u.wr_reg(6'h3F, 8'hFF);
    rd_chk(6'h3F, 8'h00);
    host_u.wr_rd(RFCFG_ADDR_MOD_WIDTH, 8'h40, d);
    check(d, 8'h40);
    host_u.wr_rd(RFCFG_ADDR_NDRV, 8'h9C, d);
    check(d, 8'h9C);
    host_u.wr_rd(RFCFG_ADDR_PDRV_CW, 8'hEA, d);
    check(d, 8'h2A);
    host_u.wr_rd(RFCFG_ADDR_RX_GAIN, 8'hA7, d);
    check(d, 8'h28);
    host_u.wr_rd(RFCFG_ADDR_RSVD_A, 8'h11, d);
    check(d, 8'h88);
  endtask

  task t_gain;
    for (int c = 0; c < 8; c++) begin
      host_u.wr_reg(RFCFG_ADDR_RX_GAIN, {1'b0, 3'(c), 4'h0});
      settle();
      check({2'h0, gain_db}, db_exp[c]);
      check({5'h00, gain_code}, 8'(c));
    end
  endtask

  task t_drive;
    host_u.wr_reg(RFCFG_ADDR_NDRV, 8'h25);
    host_u.wr_reg(RFCFG_ADDR_PDRV_CW, 8'h15);
    settle();
    check({4'h0, drive.ndrv}, 8'h00);
    check({2'h0, drive.pdrv}, 8'h15);
    @(posedge clk_i);
    one_on <= 1'b1;
    settle();
    check({4'h0, drive.ndrv}, 8'h02);
    @(posedge clk_i);
    soft_pd <= 1'b1;
    settle();
    check({4'h0, drive.ndrv}, 8'h0A);
    check({2'h0, drive.pdrv}, 8'h35);
    @(posedge clk_i);
    soft_pd <= 1'b0;
    one_on <= 1'b0;
    two_on <= 1'b1;
    settle();
    check({4'h0, drive.ndrv}, 8'h02);
  endtask

  // Start is held into the pulse; the second request must be ignored
  task t_mod;
    int n;
    host_u.wr_reg(RFCFG_ADDR_MOD_WIDTH, 8'h03);
    @(posedge clk_i);
    mod_start <= 1'b1;
    @(posedge clk_i);
    #1;
    n = 0;
    while (mod_pulse === 1'b1 && n < 40) begin
      n++;
      if (n == 2) check({4'h0, drive.ndrv}, 8'h05);
      @(posedge clk_i);
      if (n == 1) mod_start <= 1'b0;
      #1;
    end
    check(8'(n), 8'h04);
    settle();
    check({7'h00, mod_pulse}, 8'h00);
    check({4'h0, drive.ndrv}, 8'h02);
  endtask

  // ===========================================================================
  // Sequence, watchdog and verdict
  task wrap_up;
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_rw();
    t_gain();
    t_drive();
    t_mod();
    wrap_up();
  end

  // The sequence needs well under a thousand cycles
  initial begin
    #100000;
    error_cnt++;
    wrap_up();
  end
endmodule // test_rf_frontend_config_regs
